//--- include/rldwa_pkg.sv
// Package with constants, types and helpers of the receive lock, deserializer and word aligner
package rldwa_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_PATTERN = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_WORD    = 8'h0C;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0101;
  localparam logic [31:0] PATTERN_RESET = 32'h0000_017C;

  // Offset cancellation run length and sync state machine thresholds
  localparam int          CAL_CYCLES_DEF = 256;
  localparam logic [1:0]  SM_ACQ_COUNT   = 2'h3;
  localparam logic [2:0]  SM_LOSS_COUNT  = 3'h4;
  localparam int          HIST_BITS      = 32;

  // Parallel interface widths
  typedef enum logic [1:0] {
    RLDWA_W8  = 2'h0,
    RLDWA_W10 = 2'h1,
    RLDWA_W16 = 2'h2,
    RLDWA_W20 = 2'h3
  } rldwa_width_t;

  // Word alignment modes
  typedef enum logic [1:0] {
    RLDWA_AL_MANUAL  = 2'h0,
    RLDWA_AL_SYNC_SM = 2'h1,
    RLDWA_AL_BITSLIP = 2'h2
  } rldwa_align_t;

  // Functional modes
  typedef enum logic [2:0] {
    RLDWA_PR_BASIC = 3'h0,
    RLDWA_PR_PCIE  = 3'h1,
    RLDWA_PR_XAUI  = 3'h2,
    RLDWA_PR_GIGE  = 3'h3,
    RLDWA_PR_SRIO  = 3'h4,
    RLDWA_PR_OTHER = 3'h5
  } rldwa_proto_t;

  // Alignment pattern length codes
  typedef enum logic [2:0] {
    RLDWA_PL_7  = 3'h0,
    RLDWA_PL_8  = 3'h1,
    RLDWA_PL_10 = 3'h2,
    RLDWA_PL_16 = 3'h3,
    RLDWA_PL_20 = 3'h4,
    RLDWA_PL_32 = 3'h5
  } rldwa_plen_t;

  // Synchronization states, Gray coded along loss, acquire, sync
  typedef enum logic [1:0] {
    RLDWA_SM_LOSS = 2'b00,
    RLDWA_SM_ACQ  = 2'b01,
    RLDWA_SM_SYNC = 2'b11
  } rldwa_sm_t;

  // Control register layout
  typedef struct packed {
    logic [19:0]  rsvd;
    logic         bitslip;
    logic         manual_present;
    rldwa_plen_t  pat_len;
    rldwa_proto_t proto;
    rldwa_align_t align_mode;
    rldwa_width_t width;
  } rldwa_ctrl_t;

  // Status register layout
  typedef struct packed {
    logic [24:0] rsvd;
    rldwa_sm_t   sm_state;
    logic        pattern_hit;
    logic        sync_flag;
    logic        freq_locked;
    logic        ref_track;
    logic        busy;
  } rldwa_status_t;

  // Bits in one parallel word
  function automatic logic [4:0] word_bits(input rldwa_width_t w);
    case (w)
      RLDWA_W8:  word_bits = 5'd8;
      RLDWA_W10: word_bits = 5'd10;
      RLDWA_W16: word_bits = 5'd16;
      default:   word_bits = 5'd20;
    endcase
  endfunction : word_bits

  // Bits in an alignment pattern
  function automatic logic [5:0] pat_bits(input rldwa_plen_t c);
    case (c)
      RLDWA_PL_7:  pat_bits = 6'd7;
      RLDWA_PL_8:  pat_bits = 6'd8;
      RLDWA_PL_16: pat_bits = 6'd16;
      RLDWA_PL_20: pat_bits = 6'd20;
      RLDWA_PL_32: pat_bits = 6'd32;
      default:     pat_bits = 6'd10;
    endcase
  endfunction : pat_bits

  // Supported pattern length for a width, else the width's default length
  function automatic rldwa_plen_t legal_len(input rldwa_width_t w, input rldwa_plen_t c);
    case (w)
      RLDWA_W8:  legal_len = RLDWA_PL_16;
      RLDWA_W10: legal_len = (c == RLDWA_PL_7) ? c : RLDWA_PL_10;
      RLDWA_W16: legal_len = (c == RLDWA_PL_8 || c == RLDWA_PL_32) ? c : RLDWA_PL_16;
      default:   legal_len = (c == RLDWA_PL_7 || c == RLDWA_PL_10) ? c : RLDWA_PL_20;
    endcase
  endfunction : legal_len

endpackage : rldwa_pkg

//--- verilog/rldwa_top.sv
// Receive lock controller, deserializer and word aligner with AXI4-Lite registers
// Overview of operation
// - Request inputs select ref, data or automatic mode
// - Without request inputs, lock stays automatic
// - Automatic mode starts in reference tracking
// - Data tracking needs detect, frequency and phase lock
// - Signal detect counts only in PCIe mode
// - Return to reference on lost detect and frequency
// - Frequency locked flag follows each mode change
// - Manual mode follows request levels directly
// - Offset cancellation runs once after power on
// - Busy high during cancellation; analog reset ignored
// - Deserializer makes 8, 10, 16, 20 bit words
// - First received bit is word LSB
// - Aligner modes: manual, sync machine, bit slip
// - Sync machine only in listed modes
// - Pattern lengths limited per interface width
// - Single width manual sync pulses; enable sensitivity
// - Double width sync drops on enable edge
// - Sync machine flag high while synchronized
// - Pattern hit pulses once per matching word
`timescale 1ns/1ps
module rldwa_top #(
  parameter int CAL_CYCLES = rldwa_pkg::CAL_CYCLES_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_in,
  input  wire logic        signal_detect,
  input  wire logic        ppm_within,
  input  wire logic        phase_within,
  input  wire logic        rx_analog_rst,
  input  wire logic        lock_to_ref_req,
  input  wire logic        lock_to_data_req,
  input  wire logic        align_enable,
  input  wire logic        pcs_reset,
  output logic             busy,
  output logic             ref_track_mode,
  output logic             freq_locked_flag,
  output logic [19:0]      rx_word,
  output logic             word_valid,
  output logic             sync_flag,
  output logic             pattern_hit
);

  rldwa_pkg::rldwa_ctrl_t ctrl;
  logic [31:0]            pattern;
  logic [4:0]             pin_meta;
  logic [4:0]             pin_sync;
  logic                   ser_bit;
  logic                   sig_det;
  logic                   ppm_ok;
  logic                   phase_ok;
  logic                   ana_rst;
  logic [31:0]            cal_cnt;
  logic                   next_ref_track;
  logic                   is_pcie;
  logic                   sd_present;
  logic                   sd_absent;
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   do_write;
  logic                   slip_req;
  logic [31:0]            ctrl_wr;
  logic [31:0]            pat_wr;

  // Pins from the analog front end cross into aclk through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 5'h0_0;
      pin_sync <= 5'h0_0;
    end else begin
      pin_meta <= {rx_analog_rst, phase_within, ppm_within, signal_detect, serial_in};
      pin_sync <= pin_meta;
    end
  end
  assign ser_bit  = pin_sync[0];
  assign sig_det  = pin_sync[1];
  assign ppm_ok   = pin_sync[2];
  assign phase_ok = pin_sync[3];
  assign ana_rst  = pin_sync[4] && !busy;  // Analog reset has no effect while busy

  // Offset cancellation: one run from reset release, busy throughout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_cnt <= 32'(CAL_CYCLES);
    end else if (cal_cnt != 32'h0000_0000) begin
      cal_cnt <= cal_cnt - 32'h0000_0001;
    end
  end
  assign busy = (cal_cnt != 32'h0000_0000);

  // Signal detect is only meaningful in PCIe mode; elsewhere both senses read true
  assign is_pcie    = (ctrl.proto == rldwa_pkg::RLDWA_PR_PCIE);
  assign sd_present = is_pcie ? sig_det : 1'b1;
  assign sd_absent  = is_pcie ? !sig_det : 1'b1;

  // Lock mode selection; data request outranks reference request
  always_comb begin
    next_ref_track = ref_track_mode;
    if (ana_rst) begin
      next_ref_track = 1'b1;
    end else if (ctrl.manual_present && lock_to_data_req) begin
      next_ref_track = 1'b0;
    end else if (ctrl.manual_present && lock_to_ref_req) begin
      next_ref_track = 1'b1;
    end else if (ref_track_mode) begin
      // Automatic mode whenever requests are absent or both low
      if (sd_present && ppm_ok && phase_ok) begin
        next_ref_track = 1'b0;
      end
    end else if (sd_absent && !ppm_ok) begin
      next_ref_track = 1'b1;
    end
  end

  // Mode and flag registers; reset lands in reference tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_track_mode   <= 1'b1;
      freq_locked_flag <= 1'b0;
    end else begin
      ref_track_mode   <= next_ref_track;
      freq_locked_flag <= !next_ref_track;
    end
  end

  // ---- Deserializer and word aligner ----
  rldwa_pkg::rldwa_width_t wsel;
  rldwa_pkg::rldwa_plen_t  lcode;
  rldwa_pkg::rldwa_sm_t    sm_state;
  rldwa_pkg::rldwa_sm_t    next_sm;
  logic                    al_rst;
  logic                    bit_en;
  logic [31:0]             hist;
  logic [31:0]             next_hist;
  logic [4:0]              wb;
  logic [5:0]              plen;
  logic [4:0]              eidx;
  logic [4:0]              bit_idx;
  logic [4:0]              idx_adv;
  logic [4:0]              idx_eff;
  logic [31:0]             win;
  logic [31:0]             mask;
  logic                    match;
  logic                    aligned_hit;
  logic                    may_align;
  logic                    realign;
  logic                    adopt;
  logic                    word_done;
  logic                    slip_pend;
  logic                    use_sm;
  logic                    manual;
  logic                    double_w;
  logic                    align_q;
  logic                    align_rise;
  logic                    armed;
  logic                    arm_now;
  logic                    sync_dw;
  logic                    next_sync_dw;
  logic                    hit_acc;
  logic                    new_acc;
  logic [1:0]              acq_cnt;
  logic [2:0]              bad_cnt;
  logic                    sync_now;

  assign al_rst   = !aresetn || pcs_reset;  // User holds PCS in reset until clock settles
  assign bit_en   = !ref_track_mode && !busy;
  assign wsel     = ctrl.width;
  assign double_w = (wsel == rldwa_pkg::RLDWA_W16) || (wsel == rldwa_pkg::RLDWA_W20);
  assign lcode    = rldwa_pkg::legal_len(wsel, ctrl.pat_len);
  assign wb       = rldwa_pkg::word_bits(wsel);
  assign plen     = rldwa_pkg::pat_bits(lcode);
  // Pattern ends on the word's last bit when longer than a word, else inside it
  assign eidx     = (plen > {1'b0, wb}) ? wb - 5'd1 : 5'(plen - 6'd1);

  // The sync machine exists only for the listed modes, Basic just at 10 bits
  assign use_sm = (ctrl.align_mode == rldwa_pkg::RLDWA_AL_SYNC_SM) &&
                  ((ctrl.proto == rldwa_pkg::RLDWA_PR_BASIC && wsel == rldwa_pkg::RLDWA_W10) ||
                   ctrl.proto == rldwa_pkg::RLDWA_PR_PCIE || ctrl.proto == rldwa_pkg::RLDWA_PR_XAUI ||
                   ctrl.proto == rldwa_pkg::RLDWA_PR_GIGE ||
                   ctrl.proto == rldwa_pkg::RLDWA_PR_SRIO);
  // An unsupported sync request falls back to manual alignment
  assign manual = (ctrl.align_mode != rldwa_pkg::RLDWA_AL_BITSLIP) && !use_sm;

  // Newest bit enters at the top so the oldest of a word lands in its LSB
  assign next_hist = {ser_bit, hist[31:1]};
  assign win       = next_hist >> (6'd32 - plen);
  assign mask      = (plen == 6'd32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << plen) - 32'h0000_0001);
  assign match     = bit_en && (((win ^ pattern) & mask) == 32'h0000_0000);

  // Bit slip holds the index for one bit, moving the boundary by one
  assign idx_adv     = slip_pend ? bit_idx : ((bit_idx == wb - 5'd1) ? 5'd0 : bit_idx + 5'd1);
  assign aligned_hit = match && (idx_adv == eidx);
  assign align_rise  = align_enable && !align_q;
  // 10-bit single width listens to the level, others to an armed edge
  assign arm_now     = (wsel == rldwa_pkg::RLDWA_W10) ? align_enable : armed;
  assign may_align   = manual ? arm_now : (use_sm && sync_state_open(sm_state));
  assign adopt       = match && may_align;
  assign realign     = adopt && !aligned_hit;
  assign idx_eff     = realign ? eidx : idx_adv;
  assign word_done   = bit_en && (idx_eff == wb - 5'd1);

  function automatic logic sync_state_open(input rldwa_pkg::rldwa_sm_t s);
    sync_state_open = (s != rldwa_pkg::RLDWA_SM_SYNC);
  endfunction : sync_state_open

  // Bit history and boundary index
  always_ff @(posedge aclk) begin
    if (al_rst) begin
      hist    <= 32'h0000_0000;
      bit_idx <= 5'h0_0 - 5'd1;
    end else if (bit_en) begin
      hist    <= next_hist;
      bit_idx <= idx_eff;
    end
  end

  // Slip request from software; a new request wins over consumption
  always_ff @(posedge aclk) begin
    if (al_rst) begin
      slip_pend <= 1'b0;
    end else begin
      slip_pend <= (slip_req && ctrl.align_mode == rldwa_pkg::RLDWA_AL_BITSLIP) ||
                   (slip_pend && !bit_en);
    end
  end

  // Manual arming and double width sync level
  always_comb begin
    next_sync_dw = sync_dw;
    if (adopt) begin
      next_sync_dw = 1'b1;
    end else if (align_rise) begin
      next_sync_dw = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (al_rst) begin
      align_q <= 1'b0;
      armed   <= 1'b1;
      sync_dw <= 1'b0;
    end else begin
      align_q <= align_enable;
      armed   <= align_rise || (armed && !adopt);  // Rising edge re-arms
      sync_dw <= next_sync_dw;
    end
  end

  // Synchronization state machine
  always_comb begin
    next_sm = sm_state;
    case (sm_state)
      rldwa_pkg::RLDWA_SM_LOSS: begin
        if (match) begin
          next_sm = rldwa_pkg::RLDWA_SM_ACQ;
        end
      end
      rldwa_pkg::RLDWA_SM_ACQ: begin
        if (aligned_hit && acq_cnt == rldwa_pkg::SM_ACQ_COUNT - 2'd1) begin
          next_sm = rldwa_pkg::RLDWA_SM_SYNC;
        end
      end
      rldwa_pkg::RLDWA_SM_SYNC: begin
        if (match && !aligned_hit && bad_cnt == rldwa_pkg::SM_LOSS_COUNT - 3'd1) begin
          next_sm = rldwa_pkg::RLDWA_SM_LOSS;
        end
      end
      default: begin
        next_sm = rldwa_pkg::RLDWA_SM_LOSS;
      end
    endcase
  end

  // Counts of good patterns while acquiring and stray ones while in sync
  always_ff @(posedge aclk) begin
    if (al_rst || !use_sm) begin
      sm_state <= rldwa_pkg::RLDWA_SM_LOSS;
      acq_cnt  <= 2'h0;
      bad_cnt  <= 3'h0;
    end else begin
      sm_state <= next_sm;
      if (realign) begin
        acq_cnt <= 2'h1;
      end else if (aligned_hit && sm_state == rldwa_pkg::RLDWA_SM_ACQ) begin
        acq_cnt <= acq_cnt + 2'h1;
      end
      if (aligned_hit || next_sm != rldwa_pkg::RLDWA_SM_SYNC) begin
        bad_cnt <= 3'h0;
      end else if (match) begin
        bad_cnt <= bad_cnt + 3'h1;
      end
    end
  end

  // Flag level presented at the next word edge
  always_comb begin
    if (use_sm) begin
      sync_now = (next_sm == rldwa_pkg::RLDWA_SM_SYNC);
    end else if (!manual) begin
      sync_now = 1'b0;  // Bit slip offers no sync status
    end else if (double_w) begin
      sync_now = next_sync_dw;
    end else begin
      sync_now = new_acc || realign;  // New boundary in this word
    end
  end

  // Status gathered across a word; word and flags hold for one word period, word_valid pulses for one cycle
  always_ff @(posedge aclk) begin
    if (al_rst) begin
      hit_acc     <= 1'b0;
      new_acc     <= 1'b0;
      rx_word     <= 20'h0_0000;
      word_valid  <= 1'b0;
      sync_flag   <= 1'b0;
      pattern_hit <= 1'b0;
    end else begin
      word_valid <= word_done;
      if (word_done) begin
        rx_word     <= 20'(next_hist >> (6'd32 - {1'b0, wb}));
        pattern_hit <= hit_acc || aligned_hit || realign;
        sync_flag   <= sync_now;
        hit_acc     <= 1'b0;
        new_acc     <= 1'b0;
      end else begin
        hit_acc <= hit_acc || aligned_hit || realign;
        new_acc <= new_acc || realign;
      end
    end
  end

  // ---- AXI4-Lite slave ----
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign slip_req      = do_write && aw_addr == rldwa_pkg::REG_CTRL && w_strb[1] && w_data[11];

  // Byte lane merge of write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  assign ctrl_wr = merge(ctrl, w_data, w_strb);
  assign pat_wr  = merge(pattern, w_data, w_strb);

  // Address and data are taken in either order, then written together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rldwa_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == rldwa_pkg::REG_CTRL || aw_addr == rldwa_pkg::REG_PATTERN) ?
                        rldwa_pkg::RESP_OKAY : rldwa_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; the slip bit is a strobe and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl    <= rldwa_pkg::CTRL_RESET;
      pattern <= rldwa_pkg::PATTERN_RESET;
    end else if (do_write) begin
      if (aw_addr == rldwa_pkg::REG_CTRL) begin
        ctrl         <= ctrl_wr;
        ctrl.bitslip <= 1'b0;
        ctrl.rsvd    <= 20'h0_0000;
      end
      if (aw_addr == rldwa_pkg::REG_PATTERN) begin
        pattern <= pat_wr;
      end
    end
  end

  // Read path; unmapped addresses return zero with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= rldwa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rldwa_pkg::RESP_OKAY;
      case (s_axi_araddr)
        rldwa_pkg::REG_CTRL:    s_axi_rdata <= ctrl;
        rldwa_pkg::REG_PATTERN: s_axi_rdata <= pattern;
        rldwa_pkg::REG_STATUS:  s_axi_rdata <= {25'h000_0000, sm_state, pattern_hit, sync_flag,
                                                freq_locked_flag, ref_track_mode, busy};
        rldwa_pkg::REG_WORD:    s_axi_rdata <= {12'h000, rx_word};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= rldwa_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : rldwa_top

//--- test/rldwa_sva.sv
// Port checker for the lock controller, deserializer and aligner
`timescale 1ns/1ps
module rldwa_sva #(
  parameter int CAL_CYCLES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic ppm_within,
  input wire logic phase_within,
  input wire logic lock_to_data_req,
  input wire logic pcs_reset,
  input wire logic busy,
  input wire logic ref_track_mode,
  input wire logic freq_locked_flag,
  input wire logic word_valid,
  input wire logic sync_flag,
  input wire logic pattern_hit
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Busy cycles since reset, to bound the calibration run
  logic [15:0] cal_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) cal_cnt <= 16'h0000;
    else if (busy) cal_cnt <= cal_cnt + 16'h0001;
  end
  // Detector levels pass two sync flops before they act
  sequence s_auto; $past(ppm_within, 3) && $past(phase_within, 3); endsequence
  sequence s_man; $past(lock_to_data_req, 1) || $past(lock_to_data_req, 2); endsequence
  property p_frq; freq_locked_flag != ref_track_mode; endproperty
  a_frq: assert property (p_frq) else $error("flag disagrees with mode");
  property p_ltd; $fell(ref_track_mode) |-> s_auto or s_man; endproperty
  a_ltd: assert property (p_ltd) else $error("data mode without cause");
  property p_once; !busy |=> !busy; endproperty
  a_once: assert property (p_once) else $error("busy rose again");
  property p_blen; $fell(busy) |-> cal_cnt >= CAL_CYCLES - 1 && cal_cnt <= CAL_CYCLES + 1; endproperty
  a_blen: assert property (p_blen) else $error("busy length wrong");
  property p_wvb; word_valid |-> !busy; endproperty
  a_wvb: assert property (p_wvb) else $error("word while busy");
  property p_wvp; word_valid |=> !word_valid; endproperty
  a_wvp: assert property (p_wvp) else $error("word strobe too long");
  property p_flag;
    $changed(sync_flag) || $changed(pattern_hit) |-> word_valid || $past(word_valid) || $past(pcs_reset);
  endproperty
  a_flag: assert property (p_flag) else $error("flag moved off word edge");
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped early");
endmodule : rldwa_sva

bind rldwa_top rldwa_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.*);

//--- test/rldwa_tx_model.sv
// Upstream serial sender feeding the receive channel
`timescale 1ns/1ps
module rldwa_tx_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       pause,
  input  wire logic [9:0] tx_word,
  output logic            serial_in
);
  logic [3:0] bit_idx;
  // A pause toggles the line so a stall never looks like a held bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_idx   <= 4'h0;
      serial_in <= 1'b0;
    end else if (pause) begin
      serial_in <= ~serial_in;
    end else begin
      serial_in <= tx_word[bit_idx];
      bit_idx   <= (bit_idx == 4'h9) ? 4'h0 : bit_idx + 4'h1;
    end
  end
endmodule : rldwa_tx_model

//--- test/tb_top.sv
// Self-checking bench for the lock controller, deserializer and aligner
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, serial_in, signal_detect, ppm_within, phase_within, pause;
  logic        rx_analog_rst, lock_to_ref_req, lock_to_data_req, align_enable, pcs_reset;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        busy, ref_track_mode, freq_locked_flag, word_valid, sync_flag, pattern_hit;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [9:0]  tx_word;
  logic [19:0] rx_word;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [31:0] exp_q[$];
  int          bad_count, total_checks, seed, n;

  rldwa_top #(.CAL_CYCLES(8)) dut (.*);
  rldwa_tx_model u_tx (.*);

  // Bench supplies the only clock, which also stands in for the cancellation clock
  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task final_report;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  function automatic logic sig(input int k);
    sig = (k == 0) ? busy : (k == 1) ? ref_track_mode : sync_flag;
  endfunction : sig

  // Bounded wait for a status level
  task automatic wt(input int k, input logic v);
    for (n = 0; n < 500 && sig(k) !== v; n++) @(posedge aclk);
  endtask : wt

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    bit aw, w;
    @(posedge aclk);
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready && !aw) begin aw = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !w) begin w = 1; s_axi_wvalid <= 1'b0; end
    end while (!(aw && w));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // Each completed word is matched against the oldest note
  always @(posedge aclk) if (word_valid === 1'b1 && exp_q.size() > 0)
    chk({11'h000, pattern_hit, rx_word}, exp_q.pop_front());

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  initial begin
    aclk = 0;
    aresetn = 0;
    seed = 62606;
    {pause, tx_word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {signal_detect, ppm_within, phase_within, rx_analog_rst} = 4'h0;
    {lock_to_ref_req, lock_to_data_req, align_enable, pcs_reset} = 4'h0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rx_analog_rst <= 1'b1;
    @(posedge aclk);
    chk({busy, ref_track_mode, freq_locked_flag}, 3'h6);
    rx_analog_rst <= 1'b0;
    axi_rd(8'h00);
    chk(d, 32'h0000_0101);
    axi_rd(8'h04);
    chk(d, 32'h0000_017C);
    axi_rd(8'hF0);
    chk(r, rldwa_pkg::RESP_SLVERR);
    axi_wr(8'h08, 32'hFFFF_FFFF);
    chk(r, rldwa_pkg::RESP_SLVERR);
    wt(0, 1'b0);
    // Basic protocol: detector ignored
    ppm_within <= 1'b1;
    phase_within <= 1'b1;
    wt(1, 1'b0);
    chk(freq_locked_flag, 1'b1);
    ppm_within <= 1'b0;
    wt(1, 1'b1);
    chk(freq_locked_flag, 1'b0);
    axi_wr(8'h00, 32'h0000_0111);
    ppm_within <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(ref_track_mode, 1'b1);
    signal_detect <= 1'b1;
    wt(1, 1'b0);
    ppm_within <= 1'b0;
    repeat (20) @(posedge aclk);
    chk(ref_track_mode, 1'b0);
    signal_detect <= 1'b0;
    wt(1, 1'b1);
    lock_to_data_req <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(ref_track_mode, 1'b1);
    axi_wr(8'h00, 32'h0000_0501);
    lock_to_ref_req <= 1'b1;
    pcs_reset <= 1'b1;
    // Junk and stalls while the receive side is held in reset
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      {pause, tx_word} <= 11'($random(seed));
    end
    chk(ref_track_mode, 1'b0);
    pause <= 1'b0;
    tx_word <= 10'h17C;
    pcs_reset <= 1'b0;
    align_enable <= 1'b1;
    wt(2, 1'b1);
    chk(sync_flag, 1'b1);
    align_enable <= 1'b0;
    repeat (4) exp_q.push_back(32'h0010_017C);
    for (n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge aclk);
    chk(exp_q.size(), 0);
    chk(sync_flag, 1'b0);
    lock_to_data_req <= 1'b0;
    wt(1, 1'b1);
    chk(ref_track_mode, 1'b1);
    final_report();
  end
endmodule : tb_top
